// *** verilog/idle_wakeup_timer.sv ***
// Idle wake-up timer top with APB register slave
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Sixteen-bit continuous down counter, count not visible to software.
// - Fast mode counts instruction cycles, slow modes count the 32 kHz clock.
// - Instruction-cycle divider stops in dual-clock or low-speed mode.
// - Underflow of tap bit 11..15 sets the pending flag.
// - Each tap underflow clears wake-up port bit 6.
// - Interrupt request needs pending, enable and global enable.
// - Pending is bit 5, enable bit 4 of interrupt control.
// - Codes 0..4 give 4k..64k cycles; codes 5..7 reserved.
// - Reset clears period select to the 4,096 cycle setting.
// - Writing zeros to power-save bits 7..4 resets the device.
// - Period change may set pending spuriously; software clears it.
// - Counter also provides watchdog, halt and brown-out delay time bases.
module idle_wakeup_timer (
   input  wire logic                         ref_clk,
   input  wire logic                         resetn,
   input  wire logic                         oscTick,
   input  wire logic                         slowClkIn,
   input  wire logic                         globalIntEnable,
   input  wire logic [7:0]                   wakePortIn,
   input  wire logic                         wakePortWr,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [7:0]                   paddr,
   input  wire logic [31:0]                  pwdata,
   output logic [31:0]                       prdata,
   output logic                              pready,
   output logic                              pslverr,
   output logic                              idleIrq,
   output logic [7:0]                        wakePortData,
   output logic                              powerSaveReset,
   output idle_timer_pkg::time_base_t        timeBase
);
   // -----------------------------
   // Reset release
   // -----------------------------
   logic rst1_r, rstn_r;
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rst1_r <= 1'b0;
         rstn_r <= 1'b0;
      end else begin
         rst1_r <= 1'b1;
         rstn_r <= rst1_r;
      end
   end

   // -----------------------------
   // Registers
   // -----------------------------
   logic [7:0] periodPower_r;
   logic       pend_r;
   logic       irqEn_r;
   logic       pwrRst_r;
   logic [2:0] div_r;
   logic       instTick;
   logic       slowSync;
   logic       slowPrev_r;
   logic       slowTick;
   logic       slowMode;
   logic       tick;
   logic       tapUnderflow;
   logic [15:0] count;

   idle_timer_pkg::apb_req_t req;
   assign req = '{sel: psel, en: penable, wr: pwrite, addr: paddr, wdata: pwdata};

   // -----------------------------
   // Address decode
   // -----------------------------
   // Whole byte address must match; a partial decode would alias the map
   function automatic logic addr_hit(
      input logic [7:0] addr,
      input logic [7:0] offset
   );
      return (addr == offset);
   endfunction : addr_hit

   wire access  = req.sel & req.en;
   wire wrAcc   = access & req.wr;
   wire rdSetup = req.sel & ~req.en & ~req.wr;
   wire hitPer  = addr_hit(req.addr, idle_timer_pkg::PeriodPowerOff);
   wire hitInt  = addr_hit(req.addr, idle_timer_pkg::IntCtrlOff);
   wire hitStat = addr_hit(req.addr, idle_timer_pkg::StatusOff);
   wire mapped  = hitPer | hitInt | hitStat;
   wire wrPer   = wrAcc & hitPer;
   wire wrInt   = wrAcc & hitInt;

   // Slow modes: dual-clock enable or high-speed oscillator off
   assign slowMode = periodPower_r[idle_timer_pkg::PwrLsb + 1] | ~periodPower_r[idle_timer_pkg::PwrLsb + 2];

   // -----------------------------
   // Clock selection
   // -----------------------------
   sync3 u_slowSync (
      .ref_clk (ref_clk),
      .rstn    (rstn_r),
      .din     (slowClkIn),
      .dout    (slowSync)
   );

   assign instTick = (div_r == 3'(idle_timer_pkg::OscPerInst - 1)) & oscTick;
   assign slowTick = slowSync & ~slowPrev_r;
   assign tick     = slowMode ? slowTick : instTick;

   // Divider parked at zero in slow modes so it stops toggling
   wire [2:0] div_nxt = (slowMode | instTick) ? 3'h0 :
                        oscTick ? (div_r + 3'h1) : div_r;

   always_ff @(posedge ref_clk or negedge rstn_r) begin
      if (!rstn_r) begin
         div_r <= 3'h0;
      end else begin
         div_r <= div_nxt;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn_r) begin
      if (!rstn_r) begin
         slowPrev_r <= 1'b0;
      end else begin
         slowPrev_r <= slowSync;
      end
   end

   idle_counter u_counter (
      .ref_clk      (ref_clk),
      .rstn         (rstn_r),
      .tick         (tick),
      .periodSel    (periodPower_r[2:0]),
      .count        (count),
      .tapUnderflow (tapUnderflow)
   );

   // -----------------------------
   // Time-base outputs
   // -----------------------------
   // Start-up delays run off the full 16-bit wrap, not the selected tap
   wire wrapNow = tick & (count == 16'h0000);
   idle_timer_pkg::time_base_t timeBase_nxt;
   assign timeBase_nxt = '{wdTick: tapUnderflow, haltDelayTick: wrapNow, brownoutDelayTick: wrapNow};

   always_ff @(posedge ref_clk or negedge rstn_r) begin
      if (!rstn_r) begin
         timeBase <= '0;
      end else begin
         timeBase <= timeBase_nxt;
      end
   end

   // -----------------------------
   // Register writes
   // -----------------------------
   wire [7:0] wb = req.wdata[7:0];
   // Reserved codes fall back to the longest defined period
   wire [2:0] selWr = (wb[2:0] > idle_timer_pkg::SelMax) ? idle_timer_pkg::SelMax : wb[2:0];
   // Reserved bit forced low regardless of software
   wire [7:0] periodPower_nxt = wrPer ? {wb[7:4], 1'b0, selWr} : periodPower_r;
   wire       pwrRst_nxt      = wrPer & (wb[7:4] == 4'h0);
   wire       irqEn_nxt       = wrInt ? wb[idle_timer_pkg::EnBit] : irqEn_r;
   // Hardware set beats software clear in the same cycle
   wire       pend_nxt        = tapUnderflow | (wrInt ? wb[idle_timer_pkg::PendBit] : pend_r);

   always_ff @(posedge ref_clk or negedge rstn_r) begin
      if (!rstn_r) begin
         periodPower_r <= idle_timer_pkg::PeriodPowerRst;
      end else begin
         periodPower_r <= periodPower_nxt;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn_r) begin
      if (!rstn_r) begin
         pwrRst_r <= 1'b0;
      end else begin
         pwrRst_r <= pwrRst_nxt;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn_r) begin
      if (!rstn_r) begin
         irqEn_r <= 1'b0;
      end else begin
         irqEn_r <= irqEn_nxt;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn_r) begin
      if (!rstn_r) begin
         pend_r <= 1'b0;
      end else begin
         pend_r <= pend_nxt;
      end
   end

   // -----------------------------
   // Wake-up port bit
   // -----------------------------
   // Tap clear wins over a core write landing in the same cycle
   logic [7:0] wakePort_nxt;
   always_comb begin
      wakePort_nxt = wakePortWr ? wakePortIn : wakePortData;
      if (tapUnderflow) begin
         wakePort_nxt[idle_timer_pkg::WakeBit] = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn_r) begin
      if (!rstn_r) begin
         wakePortData <= 8'h00;
      end else begin
         wakePortData <= wakePort_nxt;
      end
   end

   assign idleIrq        = pend_r & irqEn_r & globalIntEnable;
   assign powerSaveReset = pwrRst_r;

   // -----------------------------
   // Read path
   // -----------------------------
   wire [7:0] intRead = {2'b00, pend_r, irqEn_r, 4'h0};
   wire [7:0] statRead = {6'h00, tick, slowMode};
   wire [7:0] rdSel = hitPer ? periodPower_r :
                      hitInt ? intRead :
                      hitStat ? statRead : 8'h00;
   // Latched in the setup cycle so the data stands through the access phase
   wire [31:0] prdata_nxt = rdSetup ? {24'h000000, rdSel} : prdata;

   always_ff @(posedge ref_clk or negedge rstn_r) begin
      if (!rstn_r) begin
         prdata <= 32'h00000000;
      end else begin
         prdata <= prdata_nxt;
      end
   end

   assign pready  = 1'b1;
   assign pslverr = access & ~mapped;
endmodule : idle_wakeup_timer
`default_nettype wire

// *** common/idle_timer_pkg.sv ***
// Package of constants and carriers for the idle wake-up timer
package idle_timer_pkg;
   // APB byte offsets
   localparam logic [7:0] PeriodPowerOff  = 8'h00;
   localparam logic [7:0] IntCtrlOff      = 8'h04;
   localparam logic [7:0] StatusOff       = 8'h08;
   // Field positions
   localparam int SelLsb      = 0;
   localparam int RsvdBit     = 3;
   localparam int PwrLsb      = 4;
   localparam int PendBit     = 5;
   localparam int EnBit       = 4;
   localparam int WakeBit     = 6;
   localparam int TapBase     = 11;
   // Reset values and largest period code
   localparam logic [7:0] PeriodPowerRst = 8'h50;
   localparam logic [7:0] IntCtrlRst     = 8'h00;
   localparam logic [2:0] SelMax         = 3'h4;
   // Timing: instruction cycle is oscillator over ten halves (divide by 10 of doubled clock)
   localparam int OscPerInst  = 5;
   localparam int SlowHz      = 32768;
   localparam int ClkHz       = 50000000;
   localparam int SlowDiv     = ClkHz / SlowHz;

   typedef struct packed {
      logic        wdTick;
      logic        haltDelayTick;
      logic        brownoutDelayTick;
   } time_base_t;

   typedef struct packed {
      logic        sel;
      logic        en;
      logic        wr;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } apb_req_t;
endpackage : idle_timer_pkg

// *** verilog/sync3.sv ***
// Three-stage synchroniser with agreement detection
`timescale 1ns/1ps
`default_nettype none
module sync3 (
   input  wire logic ref_clk,
   input  wire logic rstn,
   input  wire logic din,
   output logic      dout
);
   logic s1_r, s2_r, s3_r;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         dout <= 1'b0;
      end else begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            dout <= s3_r;
         end
      end
   end
endmodule : sync3
`default_nettype wire

// *** verilog/idle_counter.sv ***
// Sixteen-bit free-running down counter with tap underflow detect
`timescale 1ns/1ps
`default_nettype none
module idle_counter (
   input  wire logic       ref_clk,
   input  wire logic       rstn,
   input  wire logic       tick,
   input  wire logic [2:0] periodSel,
   output logic [15:0]     count,
   output logic            tapUnderflow
);
   logic [15:0] count_nxt;
   logic        tapNow;
   logic        tapNxt;
   assign count_nxt = count - 16'h0001;
   assign tapNow    = count[idle_timer_pkg::TapBase + periodSel];
   assign tapNxt    = count_nxt[idle_timer_pkg::TapBase + periodSel];
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         count        <= 16'h0000;
         tapUnderflow <= 1'b0;
      end else begin
         tapUnderflow <= 1'b0;
         if (tick) begin
            count        <= count_nxt;
            tapUnderflow <= ~tapNow & tapNxt;
         end
      end
   end
endmodule : idle_counter
`default_nettype wire

// *** verification/idle_wakeup_timer_checker.sv ***
// Port-level assertions for the idle wake-up timer
`timescale 1ns/1ps
`default_nettype none
module idle_wakeup_timer_checker (
   input wire logic        ref_clk,
   input wire logic        resetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        idleIrq,
   input wire logic        globalIntEnable,
   input wire logic [7:0]  wakePortIn,
   input wire logic        wakePortWr,
   input wire logic [7:0]  wakePortData,
   input wire logic        powerSaveReset
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   wire acc = psel && penable;
   wire mapped = paddr == 8'h00 || paddr == 8'h04 || paddr == 8'h08;
   sequence s_zero_write;
      acc && pwrite && paddr == idle_timer_pkg::PeriodPowerOff && pwdata[7:4] == 4'h0;
   endsequence
   chk_ready_high: assert property (pready) else $error("pready low");
   chk_err_unmapped: assert property (acc && !mapped |-> pslverr) else $error("no error on unmapped");
   chk_err_mapped: assert property (acc && mapped |-> !pslverr) else $error("error on mapped");
   chk_rd_upper: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper read bits");
   chk_irq_gate: assert property (idleIrq |-> globalIntEnable) else $error("irq without global");
   chk_psr_cause: assert property (s_zero_write |=> powerSaveReset) else $error("no reset pulse");
   chk_psr_only: assert property (powerSaveReset |-> $past(acc && pwrite &&
      paddr == idle_timer_pkg::PeriodPowerOff && pwdata[7:4] == 4'h0))
      else $error("stray reset pulse");
   chk_psr_pulse: assert property (powerSaveReset |=> !powerSaveReset) else $error("long reset pulse");
   chk_wake_load: assert property (wakePortWr |=> wakePortData[5:0] == $past(wakePortIn[5:0]))
      else $error("port write lost");
   chk_wake_hold: assert property (!wakePortWr |=> $stable(wakePortData[5:0])) else $error("port bits moved");
   chk_wake_rise: assert property ($rose(wakePortData[6]) |-> $past(wakePortWr)) else $error("bit six set");
endmodule : idle_wakeup_timer_checker
bind idle_wakeup_timer idle_wakeup_timer_checker u_chk (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .idleIrq(idleIrq), .globalIntEnable(globalIntEnable), .wakePortIn(wakePortIn),
   .wakePortWr(wakePortWr), .wakePortData(wakePortData), .powerSaveReset(powerSaveReset));
`default_nettype wire

// *** verification/far_side_model.sv ***
// Oscillator and 32 kHz clock sources of the surrounding device
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
   input  wire logic ref_clk,
   output var logic  oscTick,
   output var logic  slowClkIn
);
   int half = 0;
   initial begin
      oscTick = 1'b1;
      slowClkIn = 1'b0;
   end
   // Tick held high: fastest rate, keeps periods short
   always @(posedge ref_clk) begin
      half <= (half == idle_timer_pkg::SlowDiv / 2 - 1) ? 0 : half + 1;
      if (half == 0) slowClkIn <= ~slowClkIn;
   end
endmodule : far_side_model
`default_nettype wire

// *** verification/idle_wakeup_timer_tb.sv ***
// Self-checking bench for the idle wake-up timer
`timescale 1ns/1ps
`default_nettype none
module idle_wakeup_timer_tb;
   logic ref_clk = 0, resetn = 0, global_interrupt_enable = 0, wakePortWr = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h00, wakePortIn = 8'h00, wakeExp;
   logic [31:0] pwdata = 32'h0, prdata, seed = 32'h8f4c2edf;
   logic        pready, pslverr, idleIrq, powerSaveReset, oscTick, slowClkIn, psrSeen = 0;
   logic [7:0]  wakePortData;
   logic [32:0] expq[$];
   int          miscompares = 0, total_checks = 0, cyc = 0, t0, t1;
   int          wdCnt = 0, haltCnt = 0, brownCnt = 0, wd0;
   idle_timer_pkg::time_base_t timeBase;
   far_side_model fsm (.ref_clk(ref_clk), .oscTick(oscTick), .slowClkIn(slowClkIn));
   idle_wakeup_timer DUT (.ref_clk(ref_clk), .resetn(resetn), .oscTick(oscTick), .slowClkIn(slowClkIn),
      .globalIntEnable(global_interrupt_enable), .wakePortIn(wakePortIn), .wakePortWr(wakePortWr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .idleIrq(idleIrq), .wakePortData(wakePortData), .powerSaveReset(powerSaveReset), .timeBase(timeBase));
   initial begin
      forever #10 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) cyc <= cyc + 1;
   always @(posedge ref_clk) if (powerSaveReset === 1'b1) psrSeen <= 1'b1;
   always @(posedge ref_clk) if (timeBase.wdTick === 1'b1) wdCnt <= wdCnt + 1;
   always @(posedge ref_clk) if (timeBase.haltDelayTick === 1'b1) haltCnt <= haltCnt + 1;
   always @(posedge ref_clk) if (timeBase.brownoutDelayTick === 1'b1) brownCnt <= brownCnt + 1;
   // -------------------------------------------
   // Tasks
   // -------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
      @(posedge ref_clk);
      psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
      if (!wr) expq.push_back(e);
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1) @(posedge ref_clk);
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   task automatic wait_irq(output int t);
      @(posedge ref_clk);
      while (idleIrq !== 1'b1) @(posedge ref_clk);
      t = cyc;
   endtask : wait_irq
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up
   // Read results are taken at the completing edge
   always @(posedge ref_clk) if (psel && penable && !pwrite && pready) check({pslverr, prdata}, expq.pop_front());
   initial begin
      #1600000;
      miscompares++;
      wrap_up();
   end
   // -------------------------------------------
   // Scenarios
   // -------------------------------------------
   initial begin
      repeat (4) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge ref_clk);
      apb(0, 8'h00, 0, 33'h50);
      apb(0, 8'h04, 0, 33'h0);
      seed = xs(seed);
      apb(1, 8'h0c, seed, 0);
      apb(0, 8'h0c, 0, 33'h100000000);
      apb(1, 8'h00, 32'h57, 0);
      apb(0, 8'h00, 0, 33'h54);
      apb(1, 8'h00, 32'h50, 0);
      global_interrupt_enable <= 1'b1;
      apb(1, 8'h04, 32'h30, 0);
      apb(0, 8'h04, 0, 33'h30);
      check(idleIrq, 1'b1);
      global_interrupt_enable <= 1'b0;
      @(posedge ref_clk);
      @(posedge ref_clk);
      check(idleIrq, 1'b0);
      global_interrupt_enable <= 1'b1;
      apb(1, 8'h04, 32'h10, 0);
      wait_irq(t0);
      wd0 = wdCnt;
      seed = xs(seed);
      wakePortIn <= seed[7:0] | 8'h40;
      wakeExp = seed[7:0] & 8'hbf;
      wakePortWr <= 1'b1;
      @(posedge ref_clk);
      wakePortWr <= 1'b0;
      apb(1, 8'h04, 32'h10, 0);
      @(posedge ref_clk);
      check(idleIrq, 1'b0);
      wait_irq(t1);
      check(t1 - t0, 4096 * idle_timer_pkg::OscPerInst);
      check(wdCnt - wd0, 1);
      check(wakePortData, wakeExp);
      apb(1, 8'h00, 32'h0f, 0);
      repeat (2) @(posedge ref_clk);
      check(psrSeen, 1'b1);
      // Counter leaves reset at zero, so its first tick is the only wrap in this run
      check(haltCnt, 1);
      check(brownCnt, 1);
      wrap_up();
   end
endmodule : idle_wakeup_timer_tb
`default_nettype wire
